// [src/rcb_reset_ctrl.sv]
`timescale 1ns/1ps
`include "rcb_params.svh"
module rcb_reset_ctrl (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic RESET_PIN_N,
  input wire logic [15:0] DATA_IN,
  input wire logic BUS_ERROR_LINE_N,
  input wire logic BREAKPOINT_LINE_N,
  input wire logic CLOCK_SOURCE_SELECT,
  input wire rcb_pkg::rcb_src_s SOURCES,
  input wire logic BUS_CYCLE_ACTIVE,
  input wire logic BUS_CYCLE_END,
  output logic EXT_PIN_RESET_DRIVE,
  output logic CLOCK_MODULE_RESET,
  output logic MASTER_RESET,
  output logic BUS_MONITOR_FORCE,
  output logic BUS_CYCLE_ALLOWED,
  output rcb_pkg::rcb_src_s CAUSE,
  output logic CAUSE_PIN,
  output rcb_pkg::rcb_cfg_s CONFIG
);
  typedef enum logic [1:0] {
    RCB_RUN,
    RCB_WAIT_END,
    RCB_HOLD,
    RCB_RELEASE
  } rcb_state_e;

  logic [19:0] pins_sync;
  logic pin_low;
  logic [15:0] data_s;
  logic bus_error_line_s, breakpoint_line_s, clock_source_select_s;

  // Clock-domain crossing for every pin the block reads
  rcb_sync2 #(.W(20)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .d({RESET_PIN_N, DATA_IN, BUS_ERROR_LINE_N, BREAKPOINT_LINE_N,
        CLOCK_SOURCE_SELECT}),
    .q(pins_sync)
  );

  always_comb begin
    pin_low = !pins_sync[19];
    data_s = pins_sync[18:3];
    bus_error_line_s = pins_sync[2];
    breakpoint_line_s = pins_sync[1];
    clock_source_select_s = pins_sync[0];
  end

  rcb_state_e state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [7:0] mon, next_mon;
  logic ext_drv, next_ext_drv;
  logic clk_rst, next_clk_rst;
  logic mst_rst, next_mst_rst;
  logic mon_force, next_mon_force;
  logic allowed, next_allowed;
  rcb_pkg::rcb_src_s cause, next_cause;
  logic cause_pin, next_cause_pin;
  logic async_req, sync_req, bus_done, any_clk_src;

  always_comb begin
    // Asynchronous sources act at once
    async_req = SOURCES.power_up | SOURCES.watchdog | SOURCES.halt;
    sync_req = pin_low | SOURCES.loss_of_clock | SOURCES.test;
    // Monitor ends a cycle that never terminates
    bus_done = !BUS_CYCLE_ACTIVE | BUS_CYCLE_END |
               (mon == `RCB_BUS_MON_LIMIT);
    any_clk_src = SOURCES.power_up | SOURCES.watchdog | SOURCES.halt |
                  SOURCES.loss_of_clock | pin_low;
    next_state = state;
    next_cnt = cnt;
    next_mon = 8'h00;
    next_ext_drv = ext_drv;
    next_clk_rst = clk_rst;
    next_mst_rst = mst_rst;
    next_mon_force = 1'b0;
    next_allowed = allowed;
    next_cause = cause;
    next_cause_pin = cause_pin;
    case (state)
      RCB_RUN: begin
        if (async_req || sync_req) begin
          next_cause = SOURCES;
          next_cause_pin = pin_low;
          next_allowed = 1'b0;
        end
        if (async_req) begin
          next_state = RCB_HOLD;
          next_cnt = `RCB_HOLD_CYCLES;
        end else if (sync_req) begin
          // Wait for the bus so a write in flight completes
          next_state = RCB_WAIT_END;
          next_mon_force = 1'b1;
        end
      end
      RCB_WAIT_END: begin
        next_mon_force = 1'b1;
        if (BUS_CYCLE_ACTIVE && !BUS_CYCLE_END) begin
          next_mon = mon + 8'h01;
        end
        if (bus_done || async_req) begin
          next_state = RCB_HOLD;
          next_cnt = `RCB_HOLD_CYCLES;
          next_mon_force = 1'b0;
        end
      end
      RCB_HOLD: begin
        // Assert lines; abandoned work is simply reset
        next_mst_rst = 1'b1;
        next_ext_drv = 1'b1;
        next_clk_rst = any_clk_src | (clk_rst & !SOURCES.test);
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (!async_req && !sync_req) begin
          next_state = RCB_RELEASE;
          next_mst_rst = 1'b0;
          next_ext_drv = 1'b0;
          next_clk_rst = 1'b0;
          next_cnt = `RCB_FIRST_CYCLE_DELAY;
        end
      end
      RCB_RELEASE: begin
        // Hold off the first bus cycle for ten clocks
        if (async_req || sync_req) begin
          next_state = RCB_RUN;
        end else if (cnt != 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_allowed = 1'b1;
          next_state = RCB_RUN;
        end
      end
      default: begin
        next_state = RCB_RUN;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= RCB_HOLD;
      cnt <= `RCB_HOLD_CYCLES;
      mon <= 8'h00;
      ext_drv <= 1'b1;
      clk_rst <= 1'b1;
      mst_rst <= 1'b1;
      mon_force <= 1'b0;
      allowed <= 1'b0;
      cause <= '0;
      cause_pin <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mon <= next_mon;
      ext_drv <= next_ext_drv;
      clk_rst <= next_clk_rst;
      mst_rst <= next_mst_rst;
      mon_force <= next_mon_force;
      allowed <= next_allowed;
      cause <= next_cause;
      cause_pin <= next_cause_pin;
    end
  end

  // Configuration: pins are read while master reset is high
  rcb_pkg::rcb_cfg_s cfg, next_cfg;
  rcb_pkg::rcb_cfg_s sampled;
  localparam logic [15:0] data_default = `RCB_DATA_DEFAULT;

  always_comb begin
    // High pins give defaults, low pins alternates
    sampled.synth_clock = clock_source_select_s;
    sampled.background_en = !breakpoint_line_s;
    if (!bus_error_line_s) begin
      sampled.bus_mode = rcb_pkg::RCB_SINGLE_CHIP;
    end else if (data_s[`RCB_WIDE_BIT]) begin
      sampled.bus_mode = rcb_pkg::RCB_EXPANDED_8;
    end else begin
      sampled.bus_mode = rcb_pkg::RCB_EXPANDED_16;
    end
    sampled.module_opts = data_s[`RCB_OPT_MSB:`RCB_OPT_LSB];
    sampled.pin_funcs = data_s[`RCB_PIN_MSB:`RCB_PIN_LSB];
    sampled.boot_wide = data_s[`RCB_BOOT_BIT];
    // Capture only on the negating edge of master reset
    next_cfg = (mst_rst && !next_mst_rst) ? sampled : cfg;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cfg <= '{1'b1, 1'b0, rcb_pkg::RCB_EXPANDED_8,
               data_default[`RCB_OPT_MSB:`RCB_OPT_LSB],
               data_default[`RCB_PIN_MSB:`RCB_PIN_LSB],
               data_default[`RCB_BOOT_BIT]};
    end else begin
      cfg <= next_cfg;
    end
  end

  always_comb begin
    EXT_PIN_RESET_DRIVE = ext_drv;
    CLOCK_MODULE_RESET = clk_rst;
    MASTER_RESET = mst_rst;
    BUS_MONITOR_FORCE = mon_force;
    BUS_CYCLE_ALLOWED = allowed;
    CAUSE = cause;
    CAUSE_PIN = cause_pin;
    CONFIG = cfg;
  end

  // Release cycles counted for the first-cycle checks
  logic [3:0] gap, next_gap;

  always_comb begin
    next_gap = 4'h0;
    if (state == RCB_RELEASE) begin
      next_gap = (gap == 4'hf) ? gap : gap + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gap <= 4'h0;
    end else begin
      gap <= next_gap;
    end
  end

  a_async_fast: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_RUN && async_req) |-> ##[1:12] mst_rst)
    else $error("async reset not taken");
  a_test_noclk: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_RUN && SOURCES == 5'b00001 && !pin_low && !clk_rst)
    ##1 (SOURCES == 5'b00001 && !pin_low) [*3] |-> !clk_rst)
    else $error("test reset hit clock module");
  a_wait_bus: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_WAIT_END && BUS_CYCLE_ACTIVE && !BUS_CYCLE_END
     && mon != `RCB_BUS_MON_LIMIT && !async_req) |-> ##2 !mst_rst)
    else $error("sync reset cut a bus cycle");
  a_mon_forced: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_WAIT_END) |-> mon_force)
    else $error("bus monitor not forced");
  a_first_cycle: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    $rose(allowed) |-> gap == `RCB_FIRST_CYCLE_DELAY)
    else $error("first bus cycle timing wrong");
  a_release_len: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_RELEASE) |-> gap < `RCB_FIRST_CYCLE_DELAY)
    else $error("release wait too long");
  a_cfg_held: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!mst_rst && !$fell(mst_rst)) |-> $stable(cfg))
    else $error("configuration changed after reset");
  a_lines_tied: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    mst_rst == ext_drv)
    else $error("master and pin drive disagree");
  a_pin_sync: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state == RCB_RUN && !async_req && !SOURCES.loss_of_clock
     && !SOURCES.test && !pin_low) |-> ##1 state == RCB_RUN)
    else $error("reset without synchronised pin");
endmodule

// [src/rcb_params.svh]
`ifndef RCB_PARAMS_SVH
`define RCB_PARAMS_SVH

// Cycles from reset pin release to the first bus cycle
`define RCB_FIRST_CYCLE_DELAY 4'ha
// Bus monitor limit for a cycle that never terminates
`define RCB_BUS_MON_LIMIT 8'h40
// Cycles the master reset is held once taken
`define RCB_HOLD_CYCLES 4'h8
// Sampled data line positions
`define RCB_OPT_MSB 15
`define RCB_OPT_LSB 12
`define RCB_PIN_MSB 11
`define RCB_PIN_LSB 2
`define RCB_WIDE_BIT 1
`define RCB_BOOT_BIT 0
// Configuration reset value: all pins left high
`define RCB_DATA_DEFAULT 16'hffff

`endif

// [src/rcb_pkg.sv]
package rcb_pkg;

  typedef enum logic [1:0] {
    RCB_SINGLE_CHIP,
    RCB_EXPANDED_8,
    RCB_EXPANDED_16
  } rcb_bus_mode_e;

  typedef struct packed {
    logic power_up;
    logic watchdog;
    logic halt;
    logic loss_of_clock;
    logic test;
  } rcb_src_s;

  typedef struct packed {
    logic synth_clock;
    logic background_en;
    rcb_bus_mode_e bus_mode;
    logic [3:0] module_opts;
    logic [9:0] pin_funcs;
    logic boot_wide;
  } rcb_cfg_s;

endpackage

// [src/rcb_sync2.sv]
`timescale 1ns/1ps
module rcb_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // Idle level is high: pins default high during reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// [test/rcb_board.sv]
`timescale 1ns/1ps
module rcb_board (
  input wire logic clk,
  input wire logic pin_req,
  input wire logic dev_drive,
  input wire logic [18:0] cfg,
  output logic reset_pin_n,
  output logic [15:0] data,
  output logic bus_error_line_n,
  output logic breakpoint_line_n,
  output logic clock_source_select
);
  logic [2:0] hold = 3'h0;
  logic flip = 1'b0;
  logic drive;
  // Keep driving a few cycles past reset so the synchroniser sees it
  assign drive = pin_req || dev_drive || hold != 3'h0;
  always @(posedge clk) begin
    flip <= ~flip;
    if (pin_req || dev_drive) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign reset_pin_n = !pin_req;
  // Weak pull-ups take released data lines high
  assign data = drive ? cfg[18:3] : 16'hffff;
  // No pull-ups here: outside reset the levels wander
  assign bus_error_line_n = drive ? cfg[2] : flip;
  assign breakpoint_line_n = drive ? cfg[1] : !flip;
  assign clock_source_select = drive ? cfg[0] : flip;
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
`include "rcb_params.svh"
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic pin_req = 1'b0;
  logic bus_active = 1'b0;
  logic bus_end = 1'b0;
  logic [18:0] cfg = 19'h0dcdc;
  logic [31:0] lfsr = 32'hdcdc;
  rcb_pkg::rcb_src_s sources = 5'h00;
  logic pin_n, bus_error_line_n, breakpoint_line_n, clock_source_select;
  logic [15:0] data;
  logic ext_drive, clk_rst, mst_rst, force_mon, allowed, cause_pin;
  rcb_pkg::rcb_src_s cause;
  rcb_pkg::rcb_cfg_s config_q;
  int fails = 0;
  int samples_checked = 0;

  rcb_board rcb_board_inst (.clk(clk), .pin_req(pin_req),
    .dev_drive(ext_drive), .cfg(cfg), .reset_pin_n(pin_n), .data(data),
    .bus_error_line_n(bus_error_line_n), .breakpoint_line_n(breakpoint_line_n), .clock_source_select(clock_source_select));

  rcb_reset_ctrl rcb_reset_ctrl_inst (.CORE_CLK(clk), .RESETN(resetn),
    .RESET_PIN_N(pin_n), .DATA_IN(data), .BUS_ERROR_LINE_N(bus_error_line_n),
    .BREAKPOINT_LINE_N(breakpoint_line_n), .CLOCK_SOURCE_SELECT(clock_source_select),
    .SOURCES(sources), .BUS_CYCLE_ACTIVE(bus_active),
    .BUS_CYCLE_END(bus_end), .EXT_PIN_RESET_DRIVE(ext_drive),
    .CLOCK_MODULE_RESET(clk_rst), .MASTER_RESET(mst_rst),
    .BUS_MONITOR_FORCE(force_mon), .BUS_CYCLE_ALLOWED(allowed),
    .CAUSE(cause), .CAUSE_PIN(cause_pin), .CONFIG(config_q));

  initial begin
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Board levels: [18:3] data lines, [2] bus error, [1] breakpoint, [0] clock
  function automatic rcb_pkg::rcb_cfg_s dec(input logic [18:0] c);
    dec.synth_clock = c[0];
    dec.background_en = !c[1];
    dec.bus_mode = !c[2] ? rcb_pkg::RCB_SINGLE_CHIP :
      c[4] ? rcb_pkg::RCB_EXPANDED_8 : rcb_pkg::RCB_EXPANDED_16;
    dec.module_opts = c[18:15];
    dec.pin_funcs = c[14:5];
    dec.boot_wide = c[3];
  endfunction

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic release_chk(input logic [18:0] c);
    int n;
    n = 0;
    while (mst_rst === 1'b1 && n < 200) begin
      tick();
      n++;
    end
    chk(n < 200, "reset stuck");
    chk(config_q === dec(c), "config");
    n = 0;
    while (allowed !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    chk(n == 10, "first bus cycle");
    repeat (3) tick();
    chk(config_q === dec(c), "config moved");
    $display("test done at %0t", $time);
  endtask

  task automatic pin_reset(input logic busy, input logic hang);
    int n;
    @(posedge clk);
    cfg <= lfsr[18:0];
    lfsr = nxt(lfsr);
    bus_active <= busy;
    pin_req <= 1'b1;
    repeat (3) tick();
    chk(force_mon === 1'b1, "monitor off");
    if (hang) begin
      n = 0;
      while (mst_rst !== 1'b1 && n < 100) begin
        tick();
        n++;
      end
      chk(n == `RCB_BUS_MON_LIMIT + 2, "monitor timeout");
      @(posedge clk);
      bus_active <= 1'b0;
    end else if (busy) begin
      repeat (6) tick();
      chk(mst_rst === 1'b0, "reset mid cycle");
      @(posedge clk);
      bus_end <= 1'b1;
      bus_active <= 1'b0;
      @(posedge clk);
      bus_end <= 1'b0;
    end
    repeat (4) tick();
    chk(mst_rst === 1'b1, "no reset");
    chk(clk_rst & ext_drive & cause_pin, "reset lines");
    @(posedge clk);
    pin_req <= 1'b0;
    release_chk(cfg);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #50000;
    fails++;
    finish_test();
  end

  initial begin
    int n;
    repeat (7) @(posedge clk);
    #1;
    chk(config_q === dec(19'h7ffff), "reset config");
    @(posedge clk);
    resetn <= 1'b1;
    release_chk(cfg);
    pin_reset(1'b0, 1'b0);
    pin_reset(1'b1, 1'b0);
    pin_reset(1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      cfg <= lfsr[18:0];
      lfsr = nxt(lfsr);
      bus_active <= i < 3;
      sources <= 5'h10 >> i;
      n = 0;
      do begin
        tick();
        n++;
      end while (mst_rst !== 1'b1 && n < 9);
      chk(n <= (i < 3 ? 3 : 8), "late reset");
      chk(clk_rst === (i != 4), "clock reset");
      chk(ext_drive === 1'b1, "pin drive");
      chk(cause === 5'h10 >> i, "cause");
      @(posedge clk);
      sources <= 5'h00;
      bus_active <= 1'b0;
      release_chk(cfg);
    end
    finish_test();
  end
endmodule
